// ### include/ecr_pkg.sv
// Constants for the encoder counter register block
package ecr_pkg;

  // ***************************************************
  // Bus geometry and register byte addresses
  // ***************************************************
  localparam int ECR_ADDR_W = 6;
  localparam logic [5:0] ECR_STATUS_OFS = 6'h00;
  localparam logic [5:0] ECR_POS_LOW_OFS = 6'h04;
  localparam logic [5:0] ECR_POS_HIGH_OFS = 6'h08;
  localparam logic [5:0] ECR_POS_HOLD_OFS = 6'h0c;
  localparam logic [5:0] ECR_VEL_LOW_OFS = 6'h10;
  localparam logic [5:0] ECR_VEL_HIGH_OFS = 6'h14;
  localparam logic [5:0] ECR_VEL_HOLD_OFS = 6'h18;
  localparam logic [5:0] ECR_TMR_LOW_OFS = 6'h1c;
  localparam logic [5:0] ECR_TMR_HIGH_OFS = 6'h20;
  localparam logic [5:0] ECR_IHLD_LOW_OFS = 6'h24;
  localparam logic [5:0] ECR_CTRL_OFS = 6'h28;

  // ***************************************************
  // Status field positions
  // ***************************************************
  localparam int ECR_IDX_EN_BIT = 0;
  localparam int ECR_IDX_FLAG_BIT = 1;
  localparam int ECR_HOM_EN_BIT = 2;
  localparam int ECR_HOM_FLAG_BIT = 3;
  localparam int ECR_PCI_EN_BIT = 6;
  localparam int ECR_PCI_FLAG_BIT = 7;

  // ***************************************************
  // Control field, modes, answers and reset values
  // ***************************************************
  localparam int ECR_MODE_LSB = 0;
  localparam logic [2:0] ECR_MODE_HOME_A = 3'h3;
  localparam logic [2:0] ECR_MODE_HOME_B = 3'h4;
  localparam logic [1:0] ECR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ECR_RESP_SLVERR = 2'h2;
  localparam logic [15:0] ECR_RST16 = 16'h0000;
  localparam logic [31:0] ECR_RST32 = 32'h0000_0000;
  localparam logic [2:0] ECR_RST_MODE = 3'h0;

endpackage

// ### src/ecr_encoder_regs.sv
// Encoder counter registers with an AXI4-Lite slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module ecr_encoder_regs #(
  parameter bit VEL_WIDE = 1'b1 // Upper velocity word and hold exist
) (
  input wire logic clk_i, // Clock, 125 MHz
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic [ecr_pkg::ECR_ADDR_W-1:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i, // Write address valid
  output logic s_axi_awready_o, // Write address ready
  input wire logic [31:0] s_axi_wdata_i, // Write data
  input wire logic [3:0] s_axi_wstrb_i, // Write byte strobes
  input wire logic s_axi_wvalid_i, // Write data valid
  output logic s_axi_wready_o, // Write data ready
  output logic [1:0] s_axi_bresp_o, // Write response
  output logic s_axi_bvalid_o, // Write response valid
  input wire logic s_axi_bready_i, // Write response ready
  input wire logic [ecr_pkg::ECR_ADDR_W-1:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i, // Read address valid
  output logic s_axi_arready_o, // Read address ready
  output logic [31:0] s_axi_rdata_o, // Read data
  output logic [1:0] s_axi_rresp_o, // Read response
  output logic s_axi_rvalid_o, // Read data valid
  input wire logic s_axi_rready_i, // Read data ready
  input wire logic index_pin_i, // Index pin, asynchronous
  input wire logic home_pin_i, // Home pin, asynchronous
  input wire logic count_up_i, // Decoder step forward pulse
  input wire logic count_down_i, // Decoder step backward pulse
  output logic irq_o // Interrupt request, level
);
  import ecr_pkg::*;

  // ***************************************************
  // State record
  // ***************************************************
  typedef struct packed {
    logic aw_ok; // Write address held
    logic [5:0] aw_addr; // Held write address
    logic w_ok; // Write data held
    logic [31:0] w_data; // Held write data
    logic [3:0] w_strb; // Held strobes
    logic awready; // Address ready
    logic wready; // Data ready
    logic bvalid; // Response pending
    logic [1:0] bresp; // Response code
    logic arready; // Read address ready
    logic rvalid; // Read data pending
    logic [31:0] rdata; // Read data
    logic [1:0] rresp; // Read response code
    logic [2:0] idx_sync; // Index synchroniser
    logic idx_lvl; // Filtered index level
    logic [2:0] hom_sync; // Home synchroniser
    logic hom_lvl; // Filtered home level
    logic index_event_irq_enable; // Index enable
    logic index_event_flag; // Index flag
    logic home_event_irq_enable; // Home enable
    logic home_event_flag; // Home flag
    logic homing_irq_enable; // Homing done enable
    logic homing_complete_flag; // Homing done flag
    logic [2:0] position_init_mode; // Init mode
    logic [31:0] position_count; // Position
    logic [15:0] position_hold_value; // Position hold
    logic [31:0] velocity_count; // Velocity
    logic [15:0] velocity_hold_value; // Velocity hold
    logic [31:0] interval_timer_value; // Interval timer
    logic [31:0] interval_hold_value; // Interval hold
    logic irq; // Interrupt line
  } ecr_state_t;

  ecr_state_t st; // Registered state
  ecr_state_t next_st; // Next state

  // ***************************************************
  // Helpers
  // ***************************************************
  // Merges the low two byte lanes into a 16-bit word
  function automatic logic [15:0] ecr_merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // True when the mode selects a homing mode
  function automatic logic ecr_homing(input logic [2:0] mode);
    return (mode == ECR_MODE_HOME_A) || (mode == ECR_MODE_HOME_B);
  endfunction

  // ***************************************************
  // Next state logic
  // ***************************************************
  always_comb begin
    logic idx_rise;
    logic hom_rise;
    logic aw_have;
    logic w_have;
    logic [5:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [15:0] st_word;
    logic [31:0] rd;
    logic rd_ok;
    idx_rise = 1'b0;
    hom_rise = 1'b0;
    aw_have = 1'b0;
    w_have = 1'b0;
    wa = 6'h00;
    wd = ECR_RST32;
    ws = 4'h0;
    st_word = ECR_RST16;
    rd = ECR_RST32;
    rd_ok = 1'b0;
    next_st = st;

    // Pin synchronisers, first stage feeds only the second
    next_st.idx_sync = {st.idx_sync[1:0], index_pin_i};
    next_st.hom_sync = {st.hom_sync[1:0], home_pin_i};
    // A change counts once stages two and three agree
    if (st.idx_sync[1] == st.idx_sync[2]) begin
      next_st.idx_lvl = st.idx_sync[2];
    end
    if (st.hom_sync[1] == st.hom_sync[2]) begin
      next_st.hom_lvl = st.hom_sync[2];
    end
    idx_rise = st.idx_sync[1] & st.idx_sync[2] & ~st.idx_lvl;
    hom_rise = st.hom_sync[1] & st.hom_sync[2] & ~st.hom_lvl;

    // Counters follow the decoder steps
    if (count_up_i && !count_down_i) begin
      next_st.position_count = st.position_count + 32'h0000_0001;
      next_st.velocity_count = st.velocity_count + 32'h0000_0001;
    end else if (count_down_i && !count_up_i) begin
      next_st.position_count = st.position_count - 32'h0000_0001;
      next_st.velocity_count = st.velocity_count - 32'h0000_0001;
    end

    // Interval timer measures clocks between decoder steps
    if (count_up_i ^ count_down_i) begin
      next_st.interval_hold_value = st.interval_timer_value;
      next_st.interval_timer_value = ECR_RST32;
    end else begin
      next_st.interval_timer_value = st.interval_timer_value + 32'h0000_0001;
    end

    // Homing: a home event reinitialises the position
    if (hom_rise && ecr_homing(st.position_init_mode)) begin
      next_st.position_count = ECR_RST32;
    end

    // Write response handshake completes
    if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
    end
    // Capture write address and data in either order
    aw_have = st.aw_ok | (s_axi_awvalid_i & st.awready);
    w_have = st.w_ok | (s_axi_wvalid_i & st.wready);
    wa = st.aw_ok ? st.aw_addr : s_axi_awaddr_i;
    wd = st.w_ok ? st.w_data : s_axi_wdata_i;
    ws = st.w_ok ? st.w_strb : s_axi_wstrb_i;
    if (s_axi_awvalid_i && st.awready) begin
      next_st.aw_ok = 1'b1;
      next_st.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st.wready) begin
      next_st.w_ok = 1'b1;
      next_st.w_data = s_axi_wdata_i;
      next_st.w_strb = s_axi_wstrb_i;
    end

    // Register write once both halves are in
    if (aw_have && w_have) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = ECR_RESP_OKAY;
      case (wa)
        ECR_STATUS_OFS: begin
          // Enables are plain bits, flags clear on a written one
          if (ws[0]) begin
            next_st.index_event_irq_enable = wd[ECR_IDX_EN_BIT];
            next_st.home_event_irq_enable = wd[ECR_HOM_EN_BIT];
            next_st.homing_irq_enable = wd[ECR_PCI_EN_BIT];
            if (wd[ECR_IDX_FLAG_BIT]) begin
              next_st.index_event_flag = 1'b0;
            end
            if (wd[ECR_HOM_FLAG_BIT]) begin
              next_st.home_event_flag = 1'b0;
            end
            if (wd[ECR_PCI_FLAG_BIT]) begin
              next_st.homing_complete_flag = 1'b0;
            end
          end
        end
        ECR_POS_LOW_OFS: begin
          // Whole counter loads from low word and hold
          next_st.position_count = {st.position_hold_value,
            ecr_merge(st.position_count[15:0], wd, ws)};
        end
        ECR_POS_HIGH_OFS: begin
          next_st.position_count[31:16] =
            ecr_merge(st.position_count[31:16], wd, ws);
        end
        ECR_POS_HOLD_OFS: begin
          next_st.position_hold_value =
            ecr_merge(st.position_hold_value, wd, ws);
        end
        ECR_VEL_LOW_OFS: begin
          next_st.velocity_count = {st.velocity_hold_value,
            ecr_merge(st.velocity_count[15:0], wd, ws)};
        end
        ECR_VEL_HIGH_OFS: begin
          next_st.velocity_count[31:16] =
            ecr_merge(st.velocity_count[31:16], wd, ws);
        end
        ECR_VEL_HOLD_OFS: begin
          next_st.velocity_hold_value =
            ecr_merge(st.velocity_hold_value, wd, ws);
        end
        ECR_TMR_LOW_OFS: begin
          next_st.interval_timer_value[15:0] =
            ecr_merge(st.interval_timer_value[15:0], wd, ws);
        end
        ECR_TMR_HIGH_OFS: begin
          next_st.interval_timer_value[31:16] =
            ecr_merge(st.interval_timer_value[31:16], wd, ws);
        end
        ECR_IHLD_LOW_OFS: begin
          next_st.interval_hold_value[15:0] =
            ecr_merge(st.interval_hold_value[15:0], wd, ws);
        end
        ECR_CTRL_OFS: begin
          if (ws[0]) begin
            next_st.position_init_mode = wd[ECR_MODE_LSB+:3];
          end
        end
        default: begin
          // Unmapped address
          next_st.bresp = ECR_RESP_SLVERR;
        end
      endcase
    end

    // Hardware set wins over a clear in the same cycle
    if (idx_rise) begin
      next_st.index_event_flag = 1'b1;
    end
    if (hom_rise) begin
      next_st.home_event_flag = 1'b1;
    end
    if (hom_rise && ecr_homing(st.position_init_mode)) begin
      next_st.homing_complete_flag = 1'b1;
    end

    // Read response handshake completes
    if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
    end
    // Status word as software sees it
    st_word[ECR_IDX_EN_BIT] = st.index_event_irq_enable;
    st_word[ECR_IDX_FLAG_BIT] = st.index_event_flag;
    st_word[ECR_HOM_EN_BIT] = st.home_event_irq_enable;
    st_word[ECR_HOM_FLAG_BIT] = st.home_event_flag;
    st_word[ECR_PCI_EN_BIT] = st.homing_irq_enable;
    st_word[ECR_PCI_FLAG_BIT] = st.homing_complete_flag;

    // Register read with side effects on the position and velocity low words
    if (s_axi_arvalid_i && st.arready) begin
      rd_ok = 1'b1;
      case (s_axi_araddr_i)
        ECR_STATUS_OFS: begin
          rd = {16'h0000, st_word};
        end
        ECR_POS_LOW_OFS: begin
          rd = {16'h0000, st.position_count[15:0]};
          next_st.position_hold_value = st.position_count[31:16];
        end
        ECR_POS_HIGH_OFS: begin
          rd = {16'h0000, st.position_count[31:16]};
        end
        ECR_POS_HOLD_OFS: begin
          rd = {16'h0000, st.position_hold_value};
        end
        ECR_VEL_LOW_OFS: begin
          rd = {16'h0000, st.velocity_count[15:0]};
          next_st.velocity_hold_value = st.velocity_count[31:16];
        end
        ECR_VEL_HIGH_OFS: begin
          rd = {16'h0000, st.velocity_count[31:16]};
        end
        ECR_VEL_HOLD_OFS: begin
          rd = {16'h0000, st.velocity_hold_value};
        end
        ECR_TMR_LOW_OFS: begin
          rd = {16'h0000, st.interval_timer_value[15:0]};
        end
        ECR_TMR_HIGH_OFS: begin
          rd = {16'h0000, st.interval_timer_value[31:16]};
        end
        ECR_IHLD_LOW_OFS: begin
          rd = {16'h0000, st.interval_hold_value[15:0]};
        end
        ECR_CTRL_OFS: begin
          rd = {29'h0000_0000, st.position_init_mode};
        end
        default: begin
          // Unmapped address reads zero with an error
          rd_ok = 1'b0;
        end
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = rd_ok ? ECR_RESP_OKAY : ECR_RESP_SLVERR;
    end

    // Narrow variants have no upper velocity word or hold
    if (!VEL_WIDE) begin
      next_st.velocity_count[31:16] = ECR_RST16;
      next_st.velocity_hold_value = ECR_RST16;
    end

    // Ready flags: one transaction of each kind at a time
    next_st.awready = ~next_st.aw_ok & ~next_st.bvalid;
    next_st.wready = ~next_st.w_ok & ~next_st.bvalid;
    next_st.arready = ~next_st.rvalid;

    // Enables gate the flags onto the interrupt line
    next_st.irq =
      (next_st.index_event_flag & next_st.index_event_irq_enable) |
      (next_st.home_event_flag & next_st.home_event_irq_enable) |
      (next_st.homing_complete_flag & next_st.homing_irq_enable);
  end

  // ***************************************************
  // State register
  // ***************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.position_count <= ECR_RST32;
      st.position_hold_value <= ECR_RST16;
      st.velocity_count <= ECR_RST32;
      st.velocity_hold_value <= ECR_RST16;
      st.interval_timer_value <= ECR_RST32;
      st.interval_hold_value <= ECR_RST32;
      st.position_init_mode <= ECR_RST_MODE;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************
  // Outputs straight from the state register
  // ***************************************************
  assign s_axi_awready_o = st.awready;
  assign s_axi_wready_o = st.wready;
  assign s_axi_bresp_o = st.bresp;
  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_arready_o = st.arready;
  assign s_axi_rdata_o = st.rdata;
  assign s_axi_rresp_o = st.rresp;
  assign s_axi_rvalid_o = st.rvalid;
  assign irq_o = st.irq;

endmodule

// ### test/ecr_encoder_regs_chk.sv
// Bus handshake checker for the encoder counter registers
`timescale 1ns/1ns
module ecr_chk (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic s_axi_awvalid_i, // Write address valid
  input wire logic s_axi_awready_o, // Write address ready
  input wire logic s_axi_wvalid_i, // Write data valid
  input wire logic s_axi_wready_o, // Write data ready
  input wire logic [1:0] s_axi_bresp_o, // Write response
  input wire logic s_axi_bvalid_o, // Write response valid
  input wire logic s_axi_bready_i, // Write response ready
  input wire logic s_axi_arvalid_i, // Read address valid
  input wire logic s_axi_arready_o, // Read address ready
  input wire logic [31:0] s_axi_rdata_o, // Read data
  input wire logic [1:0] s_axi_rresp_o, // Read response
  input wire logic s_axi_rvalid_o, // Read data valid
  input wire logic s_axi_rready_i // Read data ready
);
  // ****************************************
  // Clocking and the handshake steps
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Address and data taken at one edge
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  // Read answer offered but not yet taken
  sequence s_rd_wait;
    s_axi_rvalid_o && !s_axi_rready_i;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  property p_wr_ans; s_wr_take |=> s_axi_bvalid_o; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_b_stand;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
  property p_b_done; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_aw_ref; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  a_aw_ref: assert property (p_aw_ref) else $error("write taken while answer pends");
  property p_rd_ans; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_r_stand;
    s_rd_wait |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read answer changed");
  property p_r_done; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_ar_ref; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_ar_ref: assert property (p_ar_ref) else $error("read taken while answer pends");
  property p_r_upper; s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read half set");
endmodule

bind ecr_encoder_regs ecr_chk chk_u (
  .clk_i, .sys_rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i
);

// ### test/ecr_pin_model.sv
// Encoder side model: index and home pins, step pulses
`timescale 1ns/1ns
module ecr_pin_model (
  input wire logic clk_i, // Clock
  output logic index_pin_o, // Index pin
  output logic home_pin_o, // Home pin
  output logic count_up_o, // Step forward
  output logic count_down_o // Step backward
);
  // Pins idle low from time zero
  initial begin
    index_pin_o = 1'b0;
    home_pin_o = 1'b0;
    count_up_o = 1'b0;
    count_down_o = 1'b0;
  end
  // Pulse one pin for three cycles, then let the synchroniser settle
  task automatic pin(input bit home);
    @(posedge clk_i);
    if (home) begin
      home_pin_o <= 1'b1;
    end else begin
      index_pin_o <= 1'b1;
    end
    repeat (3) @(posedge clk_i);
    home_pin_o <= 1'b0;
    index_pin_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  // One-cycle steps, gap cycles from start to start (gap of 2 or more)
  task automatic steps(input bit up, input int n, input int gap);
    repeat (n) begin
      @(posedge clk_i);
      count_up_o <= up;
      count_down_o <= !up;
      @(posedge clk_i);
      count_up_o <= 1'b0;
      count_down_o <= 1'b0;
      repeat (gap - 2) @(posedge clk_i);
    end
  endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the encoder counter registers
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module tb_top;
  import ecr_pkg::*;
  // ****************************************
  // Signals and table
  // ****************************************
  typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} ecr_row_t;
  logic clk_i = 1'b0; // Clock
  logic sys_rst_i = 1'b1; // Reset
  logic [5:0] aw_a = '0, ar_a = '0; // Addresses
  logic [31:0] w_d = '0, r_d, rv; // Data
  logic [3:0] w_s = 4'hf; // Write strobes
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0; // Master side
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, idx, hom, up, dn; // Slave side
  logic [1:0] b_resp, r_resp, rs; // Responses
  int miscompares = 0, n_tests = 0, cyc = 0; // Counters
  ecr_row_t rows[8] = '{
    '{ECR_POS_HIGH_OFS, 32'h0000_1234, 32'h0000_1234, ECR_RESP_OKAY},
    '{ECR_POS_HOLD_OFS, 32'h0000_abcd, 32'h0000_abcd, ECR_RESP_OKAY},
    '{ECR_VEL_HIGH_OFS, 32'h0000_00ff, 32'h0000_00ff, ECR_RESP_OKAY},
    '{ECR_VEL_HOLD_OFS, 32'h0000_8001, 32'h0000_8001, ECR_RESP_OKAY},
    '{ECR_TMR_HIGH_OFS, 32'h0000_0005, 32'h0000_0005, ECR_RESP_OKAY},
    '{ECR_CTRL_OFS, 32'h0000_0002, 32'h0000_0002, ECR_RESP_OKAY},
    '{ECR_STATUS_OFS, 32'h0000_0045, 32'h0000_0045, ECR_RESP_OKAY},
    '{6'h2c, 32'h0000_dead, 32'h0000_0000, ECR_RESP_SLVERR}
  };
  always #4 clk_i = ~clk_i;
  ecr_encoder_regs #(.VEL_WIDE(1'b1)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v),
    .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s),
    .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp),
    .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a),
    .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d),
    .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r),
    .index_pin_i(idx), .home_pin_i(hom), .count_up_i(up), .count_down_i(dn), .irq_o(irq)
  );
  ecr_pin_model pm_u (
    .clk_i(clk_i), .index_pin_o(idx), .home_pin_o(hom), .count_up_o(up), .count_down_o(dn)
  );
  // ****************************************
  // Bus tasks and closing
  // ****************************************
  // Write one word; answer is taken a cycle late so it must stand
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    aw_a <= a;
    w_d <= d;
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    fork
      begin
        do @(posedge clk_i); while (aw_rdy !== 1'b1);
        aw_v <= 1'b0;
      end
      begin
        do @(posedge clk_i); while (w_rdy !== 1'b1);
        w_v <= 1'b0;
      end
    join
    @(posedge clk_i);
    b_r <= 1'b1;
    do @(posedge clk_i); while (b_v !== 1'b1);
    b_r <= 1'b0;
    `CHK(b_resp, er)
  endtask
  // Read one word and compare data and response
  task automatic rc(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    do @(posedge clk_i); while (ar_rdy !== 1'b1);
    ar_v <= 1'b0;
    @(posedge clk_i);
    r_r <= 1'b1;
    do @(posedge clk_i); while (r_v !== 1'b1);
    r_r <= 1'b0;
    rv = r_d;
    rs = r_resp;
    `CHK(rv, e)
    `CHK(rs, er)
  endtask
  // Hold reset for twelve cycles
  task automatic do_rst;
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic tend(input string n);
    $display("test %s done", n);
  endtask
  // Print counts and verdict, then stop
  task automatic test_done;
    $display("compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_rst();
    // Reset values of every word but the running timer low
    for (int a = 0; a <= 40; a += 4) begin
      if (6'(a) != ECR_TMR_LOW_OFS) rc(6'(a), 32'h0000_0000);
    end
    tend("reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rc(rows[i].a, rows[i].e, rows[i].r);
    end
    // Byte strobes: only the enabled lanes land
    wr(ECR_POS_HOLD_OFS, 32'h0000_1177, ECR_RESP_OKAY, 4'h1);
    rc(ECR_POS_HOLD_OFS, 32'h0000_ab77);
    wr(ECR_STATUS_OFS, 32'h0000_00ff, ECR_RESP_OKAY, 4'h2);
    rc(ECR_STATUS_OFS, 32'h0000_0045);
    tend("table");
    // Coherent 32-bit position with carry and borrow across the halves
    wr(ECR_POS_HOLD_OFS, 32'h0000_beef);
    wr(ECR_POS_LOW_OFS, 32'h0000_ffff);
    rc(ECR_POS_HIGH_OFS, 32'h0000_beef);
    pm_u.steps(1'b1, 1, 2);
    rc(ECR_POS_LOW_OFS, 32'h0000_0000);
    rc(ECR_POS_HOLD_OFS, 32'h0000_bef0);
    pm_u.steps(1'b0, 1, 2);
    rc(ECR_POS_HIGH_OFS, 32'h0000_beef);
    tend("position");
    wr(ECR_VEL_HOLD_OFS, 32'h0000_0002);
    wr(ECR_VEL_LOW_OFS, 32'h0000_fffe);
    pm_u.steps(1'b1, 2, 2);
    rc(ECR_VEL_LOW_OFS, 32'h0000_0000);
    rc(ECR_VEL_HOLD_OFS, 32'h0000_0003);
    rc(ECR_VEL_HIGH_OFS, 32'h0000_0003);
    tend("velocity");
    // Steps twenty cycles apart capture nineteen
    wr(ECR_TMR_HIGH_OFS, 32'h0000_0007);
    pm_u.steps(1'b1, 2, 20);
    rc(ECR_IHLD_LOW_OFS, 32'h0000_0013);
    rc(ECR_TMR_HIGH_OFS, 32'h0000_0000);
    tend("interval");
    // Flags, enables and the interrupt line
    wr(ECR_STATUS_OFS, 32'h0000_0000);
    pm_u.pin(1'b0);
    rc(ECR_STATUS_OFS, 32'h0000_0002);
    `CHK(irq, 1'b0)
    wr(ECR_STATUS_OFS, 32'h0000_0001);
    `CHK(irq, 1'b1)
    wr(ECR_STATUS_OFS, 32'h0000_0003);
    rc(ECR_STATUS_OFS, 32'h0000_0001);
    `CHK(irq, 1'b0)
    pm_u.pin(1'b1);
    rc(ECR_STATUS_OFS, 32'h0000_0009);
    `CHK(irq, 1'b0)
    wr(ECR_STATUS_OFS, 32'h0000_0005);
    `CHK(irq, 1'b1)
    wr(ECR_STATUS_OFS, 32'h0000_0001);
    `CHK(irq, 1'b0)
    wr(ECR_STATUS_OFS, 32'h0000_0008);
    rc(ECR_STATUS_OFS, 32'h0000_0000);
    tend("events");
    // Homing done flag, its interrupt and the position reset only in homing modes
    wr(ECR_STATUS_OFS, 32'h0000_0040);
    for (int m = 0; m < 8; m++) begin
      wr(ECR_CTRL_OFS, 32'(m));
      wr(ECR_POS_HIGH_OFS, 32'h0000_0011);
      pm_u.pin(1'b1);
      rc(ECR_STATUS_OFS, (m == 3 || m == 4) ? 32'h0000_00c8 : 32'h0000_0048);
      `CHK(irq, 1'(m == 3 || m == 4))
      rc(ECR_POS_HIGH_OFS, (m == 3 || m == 4) ? 32'h0000_0000 : 32'h0000_0011);
      wr(ECR_STATUS_OFS, 32'h0000_00c8);
    end
    tend("modes");
    // Reset in mid-run clears counters and flags
    wr(ECR_POS_HIGH_OFS, 32'h0000_0055);
    pm_u.pin(1'b0);
    do_rst();
    rc(ECR_POS_HIGH_OFS, 32'h0000_0000);
    rc(ECR_STATUS_OFS, 32'h0000_0000);
    tend("rerun reset");
    test_done();
  end
endmodule
